// File: plnk_regs.svh
// Offsets, field positions, reset values and fixed codes of the link
// control and status word. Assumes a byte-addressed 12-bit register port.
`ifndef PLNK_REGS_SVH
`define PLNK_REGS_SVH

`define PLNK_ADDR_W           12
`define PLNK_CSR_OFFSET       12'h0d0
`define PLNK_CSR_RESET        32'h0011_0000

`define PLNK_DL_ACTIVE_BIT    29
`define PLNK_SLOT_CLK_BIT     28
`define PLNK_LANE_MSB         25
`define PLNK_LANE_LSB         20
`define PLNK_RATE_MSB         19
`define PLNK_RATE_LSB         16
`define PLNK_EXT_SYNC_BIT     7
`define PLNK_SHARED_CLK_BIT   6
`define PLNK_RETRAIN_BIT      5
`define PLNK_LINK_OFF_BIT     4
`define PLNK_BOUND_BIT        3
`define PLNK_PSC_MSB          1
`define PLNK_PSC_LSB          0

`define PLNK_LANE_VALUE       6'h01
`define PLNK_RATE_VALUE       4'h1
`define PLNK_WRITE_MASK       32'h0000_00cb
`define PLNK_READ_MASK        32'h33ff_00cb

`define PLNK_L0S_LAT_ASYNC    3'h3
`define PLNK_L0S_LAT_COMMON   3'h2
`define PLNK_L1_LAT_ASYNC     3'h0
`define PLNK_L1_LAT_COMMON    3'h0

`endif

// File: plnk_pkg.sv
// Types shared by the link control and status register block.
// Assumes plnk_regs.svh carries every number except the field codes below.
package plnk_pkg;

    typedef enum logic [1:0] {
        PLNK_PSC_OFF  = 2'h0,
        PLNK_PSC_L0S  = 2'h1,
        PLNK_PSC_RSV2 = 2'h2,
        PLNK_PSC_RSV3 = 2'h3
    } plnk_psc_type;

    typedef enum logic {
        PLNK_BOUND_64B  = 1'h0,
        PLNK_BOUND_128B = 1'h1
    } plnk_bound_type;

    typedef enum logic {
        PLNK_REFCLK_ASYNC  = 1'h0,
        PLNK_REFCLK_COMMON = 1'h1
    } plnk_refclk_type;

endpackage

// File: plnk_rw_field.sv
// One writable field of the control word, held in flip-flops.
// Assumes the caller decodes the write and supplies only the field bits.
`timescale 1ns/1ps

module plnk_rw_field #(
    parameter int                WIDTH     = 1,
    parameter logic [WIDTH-1:0]  RESET_VAL = '0
) (
    input  wire logic             clk,
    input  wire logic             arst_n,
    input  wire logic             ce,
    input  wire logic             wr_en,
    input  wire logic [WIDTH-1:0] wr_data,
    output logic      [WIDTH-1:0] q
);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= RESET_VAL;
        end else if (ce && wr_en) begin
            q <= wr_data;
        end
    end

endmodule // plnk_rw_field

// File: plnk_link_csr.sv
// Link control and status word of the bridge's capability structure.
// Assumes a same-clock register port and a same-clock EEPROM loader.
`timescale 1ns/1ps
`include "plnk_regs.svh"

module plnk_link_csr (
    input  wire logic                    clk,
    input  wire logic                    arst_n,
    input  wire logic                    ce,
    input  wire logic [`PLNK_ADDR_W-1:0] addr,
    input  wire logic [31:0]             wr_data,
    input  wire logic                    wr_en,
    input  wire logic                    rd_en,
    input  wire logic                    slot_clk_load,
    input  wire logic                    slot_clk_value,
    output logic      [31:0]             rd_data,
    output logic                         ext_sync_en,
    output logic                         shared_refclk_select,
    output logic                         completion_boundary_select,
    output logic      [1:0]              power_state_control,
    output logic                         l0s_entry_en,
    output logic      [2:0]              l0s_exit_latency,
    output logic      [2:0]              l1_exit_latency
);

    // Address decode
    wire logic csr_hit;
    wire logic wr_hit;
    wire logic rd_hit;

    assign csr_hit = (addr == `PLNK_CSR_OFFSET);
    assign wr_hit  = wr_en && csr_hit;
    assign rd_hit  = rd_en && csr_hit;

    // Writable fields; every other bit of a write is dropped here
    plnk_rw_field #(
        .WIDTH     (1),
        .RESET_VAL (1'h0)
    ) u_ext_sync (
        .clk     (clk),
        .arst_n  (arst_n),
        .ce      (ce),
        .wr_en   (wr_hit),
        .wr_data (wr_data[`PLNK_EXT_SYNC_BIT]),
        .q       (ext_sync_en)
    );

    plnk_rw_field #(
        .WIDTH     (1),
        .RESET_VAL (plnk_pkg::PLNK_REFCLK_ASYNC)
    ) u_shared_clk (
        .clk     (clk),
        .arst_n  (arst_n),
        .ce      (ce),
        .wr_en   (wr_hit),
        .wr_data (wr_data[`PLNK_SHARED_CLK_BIT]),
        .q       (shared_refclk_select)
    );

    plnk_rw_field #(
        .WIDTH     (1),
        .RESET_VAL (plnk_pkg::PLNK_BOUND_64B)
    ) u_bound (
        .clk     (clk),
        .arst_n  (arst_n),
        .ce      (ce),
        .wr_en   (wr_hit),
        .wr_data (wr_data[`PLNK_BOUND_BIT]),
        .q       (completion_boundary_select)
    );

    // Reserved codes are stored as written but never enable anything
    plnk_rw_field #(
        .WIDTH     (2),
        .RESET_VAL (plnk_pkg::PLNK_PSC_OFF)
    ) u_psc (
        .clk     (clk),
        .arst_n  (arst_n),
        .ce      (ce),
        .wr_en   (wr_hit),
        .wr_data (wr_data[`PLNK_PSC_MSB:`PLNK_PSC_LSB]),
        .q       (power_state_control)
    );

    // Slot clock bit: software cannot write it, only the EEPROM loader
    logic slot_refclk_shared;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            slot_refclk_shared <= 1'h0;
        end else if (ce && slot_clk_load) begin
            slot_refclk_shared <= slot_clk_value;
        end
    end

    // Derived control towards the link layer
    wire logic       next_l0s_entry_en;
    wire logic [2:0] next_l0s_exit_latency;
    wire logic [2:0] next_l1_exit_latency;
    wire logic       common_clk;

    assign common_clk = (shared_refclk_select
                         == plnk_pkg::PLNK_REFCLK_COMMON);
    assign next_l0s_entry_en = (power_state_control
                                == plnk_pkg::PLNK_PSC_L0S);
    // The latency shown to the partner follows the shared clock select
    // one enabled cycle after it is stored; no retraining is involved
    assign next_l0s_exit_latency = common_clk ? `PLNK_L0S_LAT_COMMON
                                              : `PLNK_L0S_LAT_ASYNC;
    assign next_l1_exit_latency  = common_clk ? `PLNK_L1_LAT_COMMON
                                              : `PLNK_L1_LAT_ASYNC;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            l0s_entry_en     <= 1'h0;
            l0s_exit_latency <= `PLNK_L0S_LAT_ASYNC;
            l1_exit_latency  <= `PLNK_L1_LAT_ASYNC;
        end else if (ce) begin
            l0s_entry_en     <= next_l0s_entry_en;
            l0s_exit_latency <= next_l0s_exit_latency;
            l1_exit_latency  <= next_l1_exit_latency;
        end
    end

    // Read word; constant and reserved bits are tied here, not stored
    wire logic [31:0] read_word;

    assign read_word = {
        2'h0,
        1'h0,
        slot_refclk_shared,
        2'h0,
        `PLNK_LANE_VALUE,
        `PLNK_RATE_VALUE,
        8'h00,
        ext_sync_en,
        shared_refclk_select,
        1'h0,
        1'h0,
        completion_boundary_select,
        1'h0,
        power_state_control
    };

    // Read data stands only in the cycle after the strobe; an unmapped
    // or idle cycle with ce high returns zero, while ce low holds rd_data
    wire logic [31:0] next_rd_data;

    assign next_rd_data = rd_hit ? read_word : 32'h0000_0000;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_data <= 32'h0000_0000;
        end else if (ce) begin
            rd_data <= next_rd_data;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence s_read_req;
        ce && rd_en && csr_hit;
    endsequence

    sequence s_write_req;
        ce && wr_en && csr_hit;
    endsequence

    sequence s_idle_cycle;
        ce && !(wr_en && csr_hit);
    endsequence

    chk_dl_active_zero: assert property (
        @(posedge clk) disable iff (!arst_n)
        !rd_data[`PLNK_DL_ACTIVE_BIT])
        else $error("data link active bit read as one");

    chk_slot_clk_load: assert property (
        @(posedge clk) disable iff (!arst_n)
        ce && slot_clk_load && !rd_en ##1 s_read_req
        |=> rd_data[`PLNK_SLOT_CLK_BIT] == $past(slot_clk_value, 2))
        else $error("slot clock bit does not show loaded value");

    chk_slot_clk_ro: assert property (
        @(posedge clk) disable iff (!arst_n)
        s_write_req ##0 !slot_clk_load
        |=> slot_refclk_shared == $past(slot_refclk_shared))
        else $error("software write changed slot clock bit");

    chk_lane_count: assert property (
        @(posedge clk) disable iff (!arst_n)
        s_read_req |=> rd_data[`PLNK_LANE_MSB:`PLNK_LANE_LSB]
                       == `PLNK_LANE_VALUE)
        else $error("lane count field wrong");

    chk_rate_field: assert property (
        @(posedge clk) disable iff (!arst_n)
        s_read_req |=> rd_data[`PLNK_RATE_MSB:`PLNK_RATE_LSB]
                       == `PLNK_RATE_VALUE)
        else $error("rate field wrong");

    chk_ext_sync_write: assert property (
        @(posedge clk) disable iff (!arst_n)
        s_write_req ##1 s_read_req
        |=> rd_data[`PLNK_EXT_SYNC_BIT] == $past(wr_data[7], 2)
            && ext_sync_en == rd_data[`PLNK_EXT_SYNC_BIT])
        else $error("extended sync bit not written back");

    chk_shared_clk_write: assert property (
        @(posedge clk) disable iff (!arst_n)
        s_write_req |=> shared_refclk_select == $past(wr_data[6]))
        else $error("shared reference clock select not stored");

    chk_exit_latency: assert property (
        @(posedge clk) disable iff (!arst_n)
        s_write_req ##1 ce[*2]
        |-> l0s_exit_latency == ($past(wr_data[6], 2)
                                 ? `PLNK_L0S_LAT_COMMON
                                 : `PLNK_L0S_LAT_ASYNC)
            && l1_exit_latency == ($past(wr_data[6], 2)
                                   ? `PLNK_L1_LAT_COMMON
                                   : `PLNK_L1_LAT_ASYNC))
        else $error("exit latency ignores reference clock setting");

    chk_retrain_zero: assert property (
        @(posedge clk) disable iff (!arst_n)
        s_write_req ##1 s_read_req |=> !rd_data[`PLNK_RETRAIN_BIT])
        else $error("retrain bit read as one");

    chk_link_off_zero: assert property (
        @(posedge clk) disable iff (!arst_n)
        s_write_req ##1 s_read_req |=> !rd_data[`PLNK_LINK_OFF_BIT])
        else $error("link disable bit read as one");

    chk_bound_write: assert property (
        @(posedge clk) disable iff (!arst_n)
        s_write_req ##1 s_read_req
        |=> rd_data[`PLNK_BOUND_BIT] == $past(wr_data[3], 2))
        else $error("completion boundary not written back");

    chk_psc_l0s: assert property (
        @(posedge clk) disable iff (!arst_n)
        s_write_req ##1 ce
        |=> l0s_entry_en == ($past(wr_data[1:0], 2)
                             == plnk_pkg::PLNK_PSC_L0S))
        else $error("L0s entry enable does not follow control field");

    chk_reserved_zero: assert property (
        @(posedge clk) disable iff (!arst_n)
        (rd_data & ~`PLNK_READ_MASK) == 32'h0000_0000)
        else $error("reserved bit read as one");

    chk_write_mask: assert property (
        @(posedge clk) disable iff (!arst_n)
        s_idle_cycle |=> $stable(ext_sync_en)
                         && $stable(shared_refclk_select)
                         && $stable(completion_boundary_select)
                         && $stable(power_state_control))
        else $error("control bits changed without a write");

    chk_reset_value: assert property (
        @(posedge clk) disable iff (!arst_n)
        $rose(arst_n) ##0 !wr_hit ##[0:1] s_read_req
        |=> rd_data == (`PLNK_CSR_RESET
                        | {3'h0, $past(slot_refclk_shared), 28'h000_0000}))
        else $error("first read after reset wrong");

    chk_read_window: assert property (
        @(posedge clk) disable iff (!arst_n)
        ce && !rd_hit |=> rd_data == 32'h0000_0000)
        else $error("read data outside its cycle");

    chk_clock_freeze: assert property (
        @(posedge clk) disable iff (!arst_n)
        !ce |=> $stable(rd_data) && $stable(l0s_entry_en)
                && $stable(l0s_exit_latency) && $stable(ext_sync_en))
        else $error("state moved while clock enable low");

    chk_ext_sync_store: assert property (
        @(posedge clk) disable iff (!arst_n)
        s_write_req |=> ext_sync_en == $past(wr_data[`PLNK_EXT_SYNC_BIT]))
        else $error("extended sync bit not stored");

    chk_bound_store: assert property (
        @(posedge clk) disable iff (!arst_n)
        s_write_req |=> completion_boundary_select
                        == $past(wr_data[`PLNK_BOUND_BIT]))
        else $error("completion boundary not stored");

    chk_psc_store: assert property (
        @(posedge clk) disable iff (!arst_n)
        s_write_req |=> power_state_control
                        == $past(wr_data[`PLNK_PSC_MSB:`PLNK_PSC_LSB]))
        else $error("power state control not stored");

    chk_l0s_follow: assert property (
        @(posedge clk) disable iff (!arst_n)
        ce |=> l0s_entry_en == ($past(power_state_control)
                                == plnk_pkg::PLNK_PSC_L0S))
        else $error("L0s entry enable wrong for stored code");

    chk_latency_follow: assert property (
        @(posedge clk) disable iff (!arst_n)
        ce |=> l0s_exit_latency == ($past(shared_refclk_select)
                                    ? `PLNK_L0S_LAT_COMMON
                                    : `PLNK_L0S_LAT_ASYNC)
               && l1_exit_latency == ($past(shared_refclk_select)
                                      ? `PLNK_L1_LAT_COMMON
                                      : `PLNK_L1_LAT_ASYNC))
        else $error("exit latency does not follow clock select");

    chk_slot_clk_read: assert property (
        @(posedge clk) disable iff (!arst_n)
        s_read_req |=> rd_data[`PLNK_SLOT_CLK_BIT]
                       == $past(slot_refclk_shared))
        else $error("slot clock bit not read back");

    chk_ctl_readback: assert property (
        @(posedge clk) disable iff (!arst_n)
        s_read_req |=> rd_data[`PLNK_EXT_SYNC_BIT] == $past(ext_sync_en)
            && rd_data[`PLNK_SHARED_CLK_BIT] == $past(shared_refclk_select)
            && rd_data[`PLNK_BOUND_BIT] == $past(completion_boundary_select)
            && rd_data[`PLNK_PSC_MSB:`PLNK_PSC_LSB]
               == $past(power_state_control))
        else $error("control bits not read back");

    chk_reset_fields: assert property (
        @(posedge clk) disable iff (!arst_n)
        $rose(arst_n) |-> !slot_refclk_shared && !ext_sync_en
                          && !shared_refclk_select
                          && !completion_boundary_select
                          && power_state_control == plnk_pkg::PLNK_PSC_OFF)
        else $error("control field not at reset value after reset");

endmodule // plnk_link_csr

// File: plnk_eeprom_model.sv
// Serial EEPROM loader model feeding the slot clock bit at power-up.
// Assumes the same clock as the register block; LAT sets reply delay.
`timescale 1ns/1ps

module plnk_eeprom_model #(
    parameter int LAT = 1
) (
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic start,
    input  wire logic value,
    output logic      slot_clk_load,
    output logic      slot_clk_value
);
    logic [LAT-1:0] pipe;

    // Outside a load the value line toggles so a stale level never passes
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pipe           <= '0;
            slot_clk_load  <= 1'h0;
            slot_clk_value <= 1'h0;
        end else begin
            pipe           <= LAT'({pipe, start});
            slot_clk_load  <= pipe[LAT-1];
            slot_clk_value <= pipe[LAT-1] ? value : ~slot_clk_value;
        end
    end
endmodule // plnk_eeprom_model

// File: tb_top.sv
// Self-checking bench for the link control and status word.
// Assumes one 40 MHz clock and an EEPROM loader model on the load port.
`timescale 1ns/1ps
`include "plnk_regs.svh"

module tb_top;
    logic                    clk;
    logic                    arst_n;
    logic                    ce;
    logic [`PLNK_ADDR_W-1:0] addr;
    logic [31:0]             wr_data;
    logic                    wr_en;
    logic                    rd_en;
    logic                    ee_start;
    logic                    ee_value;
    logic                    slot_clk_load;
    logic                    slot_clk_value;
    logic [31:0]             rd_data;
    logic                    ext_sync_en;
    logic                    shared_refclk_select;
    logic                    completion_boundary_select;
    logic [1:0]              power_state_control;
    logic                    l0s_entry_en;
    logic [2:0]              l0s_exit_latency;
    logic [2:0]              l1_exit_latency;
    int                      miscompares;
    int                      total_checks;
    int                      cycles;

    plnk_link_csr i_dut (
        .clk                        (clk),
        .arst_n                     (arst_n),
        .ce                         (ce),
        .addr                       (addr),
        .wr_data                    (wr_data),
        .wr_en                      (wr_en),
        .rd_en                      (rd_en),
        .slot_clk_load              (slot_clk_load),
        .slot_clk_value             (slot_clk_value),
        .rd_data                    (rd_data),
        .ext_sync_en                (ext_sync_en),
        .shared_refclk_select       (shared_refclk_select),
        .completion_boundary_select (completion_boundary_select),
        .power_state_control        (power_state_control),
        .l0s_entry_en               (l0s_entry_en),
        .l0s_exit_latency           (l0s_exit_latency),
        .l1_exit_latency            (l1_exit_latency)
    );

    plnk_eeprom_model #(.LAT(3)) i_ee (
        .clk            (clk),
        .arst_n         (arst_n),
        .start          (ee_start),
        .value          (ee_value),
        .slot_clk_load  (slot_clk_load),
        .slot_clk_value (slot_clk_value)
    );

    initial begin
        clk = 1'h0;
        forever #12.5 clk = ~clk;
    end

    task automatic chk(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        wr_en   <= 1'h1;
        addr    <= a;
        wr_data <= d;
        @(posedge clk);
        wr_en   <= 1'h0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        @(posedge clk);
        rd_en <= 1'h1;
        addr  <= a;
        @(posedge clk);
        rd_en <= 1'h0;
        #1;
        chk("rd_data", exp, rd_data);
    endtask

    // Write then read back with no idle cycle between the two strobes
    task automatic wr_rd(input logic [11:0] a, input logic [31:0] d,
                         input logic [31:0] exp);
        @(posedge clk);
        wr_en   <= 1'h1;
        addr    <= a;
        wr_data <= d;
        @(posedge clk);
        wr_en   <= 1'h0;
        rd_en   <= 1'h1;
        @(posedge clk);
        rd_en   <= 1'h0;
        #1;
        chk("rd_data", exp, rd_data);
    endtask

    // Control outputs packed as {ext,shared,bound,psc,l0s_en,l0s,l1}
    task automatic outs(input logic [31:0] exp);
        chk("controls", exp, {20'h0, ext_sync_en, shared_refclk_select,
            completion_boundary_select, power_state_control, l0s_entry_en,
            l0s_exit_latency, l1_exit_latency});
    endtask

    task automatic do_reset;
        @(posedge clk);
        arst_n <= 1'h0;
        repeat (3) @(posedge clk);
        arst_n <= 1'h1;
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles >= 2000) begin
            miscompares++;
            finish_test();
        end
    end

    initial begin
        miscompares  = 0;
        total_checks = 0;
        cycles       = 0;
        arst_n   = 1'h0;
        ce       = 1'h1;
        addr     = '0;
        wr_data  = '0;
        wr_en    = 1'h0;
        rd_en    = 1'h0;
        ee_start = 1'h0;
        ee_value = 1'h0;
        repeat (3) @(posedge clk);
        arst_n <= 1'h1;
        rd(`PLNK_CSR_OFFSET, 32'h0011_0000);
        outs(32'h0000_0018);
        $display("test reset done");
        // Software sets common clock and every other writable bit in one write
        wr(`PLNK_CSR_OFFSET, 32'hffff_ffff);
        rd(`PLNK_CSR_OFFSET, 32'h0011_00cb);
        outs(32'h0000_0f90);
        $display("test all ones done");
        for (int i = 0; i < 4; i++) begin
            wr_rd(`PLNK_CSR_OFFSET, 32'h0000_0040 | i,
                  32'h0011_0040 | i);
            outs(32'h0000_0410 | (i << 7)
                 | (i == 1 ? 32'h0000_0040 : 32'h0000_0000));
        end
        $display("test power codes done");
        wr_rd(`PLNK_CSR_OFFSET, 32'h0000_0000, 32'h0011_0000);
        outs(32'h0000_0018);
        wr(12'h0d4, 32'h0000_00ff);
        rd(12'h0d4, 32'h0000_0000);
        rd(`PLNK_CSR_OFFSET, 32'h0011_0000);
        @(posedge clk);
        ce <= 1'h0;
        wr(`PLNK_CSR_OFFSET, 32'h0000_0088);
        ce <= 1'h1;
        rd(`PLNK_CSR_OFFSET, 32'h0011_0000);
        $display("test refused writes done");
        @(posedge clk);
        ee_start <= 1'h1;
        ee_value <= 1'h1;
        @(posedge clk);
        ee_start <= 1'h0;
        // Read strobe lands the cycle after the load pulse
        repeat (3) @(posedge clk);
        rd(`PLNK_CSR_OFFSET, 32'h1011_0000);
        wr_rd(`PLNK_CSR_OFFSET, 32'h0000_0008, 32'h1011_0008);
        $display("test slot clock done");
        do_reset();
        rd(`PLNK_CSR_OFFSET, 32'h0011_0000);
        outs(32'h0000_0018);
        $display("test second reset done");
        finish_test();
    end
endmodule // tb_top
